// >>> fpp_front.sv
// pin front end: straps, inputs, write protection, address-mux port
// Functional notes
// - strap inputs give the part identity; boot part strapped all zeros
// - five general inputs readable by software on gp_status three clocks after they settle
// - top-lock low refuses program and erase of the top block
// - top-lock high lifts only hardware top protection; lock register still applies
// - protect pins never change stored lock register contents
// - write-protect low refuses program and erase on all non-top blocks
// - write-protect high lifts hardware protection; lock registers still apply
// - mux mode latches both address halves from shared pins and holds them
// - row/column select picks low bits 0-10 or high bits 11-19
// - address and data latched at write strobe rising edge
// - data pins driven only when output gate enables a read
// - writes feed command interpreter; reads return array, status or id
// - interface select low hub, high mux; fixed before reset release
// - reset blocks writes, resets automation, tri-states data, enters read array
// - cpu init low resets mode, status and flags like reset; interface mode capture and address registers are kept
`timescale 1ns/1ps
`default_nettype none
module fpp_front (
  input wire logic clock,
  input wire logic reset,
  input wire logic cpu_init_n,
  input wire logic interface_select,
  input wire logic [3:0] strap_identity,
  input wire logic [4:0] gp_inputs,
  input wire logic top_block_lock_n,
  input wire logic write_protect_n,
  input wire logic row_col_select_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic [7:0] data_in,
  input wire logic [15:0] lock_bits,
  input wire logic [7:0] array_rdata,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [3:0] component_id,
  output logic is_boot_part,
  output logic [4:0] gp_status,
  output logic hub_mode,
  output logic [19:0] array_addr,
  output logic [7:0] array_wdata,
  output logic array_program,
  output logic array_erase,
  output logic prot_refused,
  output logic ready
);
  typedef struct packed {
    logic [1:0][3:0] id_s;
    logic [1:0][4:0] gp_s;
    logic [1:0] tbl_s;
    logic [1:0] wp_s;
    logic [1:0] rc_s;
    logic [1:0] we_s;
    logic [1:0] oe_s;
    logic [1:0] init_s;
    logic [1:0][7:0] dq_s;
    logic [1:0] sel_s;
    logic [1:0] cap_cnt;
    logic we_prev;
    logic sel_cap;
    logic cap_done;
    logic [10:0] row;
    logic [8:0] col;
    logic [19:0] addr;
    logic [7:0] wdata;
    fpp_pkg::fpp_mode_t mode;
    logic [7:0] status;
    logic [7:0] dout;
    logic oe;
    logic [3:0] cid;
    logic boot;
    logic [4:0] gp;
    logic prog;
    logic erase;
    logic refused;
    logic rdy;
  } fpp_state_t;

  fpp_state_t st_reg;
  fpp_state_t st_next;

  function automatic logic fpp_blocked(input logic [3:0] blk, input logic tbl_n,
                                       input logic wp_n, input logic [15:0] locks);
    logic hw;
    hw = (blk == fpp_pkg::TOP_BLOCK) ? !tbl_n : !wp_n;
    fpp_blocked = hw | locks[blk];
  endfunction : fpp_blocked

  // status after a program or erase accept; error bit marks a refusal
  function automatic logic [7:0] fpp_accept_status(input logic blocked);
    logic [7:0] res;
    res = fpp_pkg::STATUS_READY;
    if (blocked) begin
      res = res | fpp_pkg::STATUS_PROT_ERR;
    end
    fpp_accept_status = res;
  endfunction : fpp_accept_status

  // row half: strap A3..A0, top lock A4, protect A5, general inputs A10..A6
  function automatic logic [10:0] fpp_row_bits(input logic [3:0] ids, input logic tbl_n,
                                               input logic wp_n, input logic [4:0] gps);
    fpp_row_bits = {gps, wp_n, tbl_n, ids};
  endfunction : fpp_row_bits

  // column half A19..A11; pin A3 and the fifth general input stay unused here
  function automatic logic [8:0] fpp_col_bits(input logic [2:0] ids, input logic tbl_n,
                                              input logic wp_n, input logic [3:0] gps);
    fpp_col_bits = {gps, wp_n, tbl_n, ids};
  endfunction : fpp_col_bits

  // command byte written while idle; unknown bytes leave the mode alone
  function automatic fpp_pkg::fpp_mode_t fpp_cmd_mode(input logic [7:0] cmd,
                                                      input fpp_pkg::fpp_mode_t cur);
    fpp_pkg::fpp_mode_t nxt;
    nxt = cur;
    case (cmd)
      fpp_pkg::CMD_PROGRAM: begin
        nxt = fpp_pkg::FPP_PROG_WAIT;
      end
      fpp_pkg::CMD_ERASE_SETUP: begin
        nxt = fpp_pkg::FPP_ERASE_WAIT;
      end
      fpp_pkg::CMD_READ_STATUS: begin
        nxt = fpp_pkg::FPP_READ_STATUS;
      end
      fpp_pkg::CMD_READ_ID: begin
        nxt = fpp_pkg::FPP_READ_ID;
      end
      fpp_pkg::CMD_READ_ARRAY: begin
        nxt = fpp_pkg::FPP_READ_ARRAY;
      end
      default: begin
        nxt = cur;
      end
    endcase
    fpp_cmd_mode = nxt;
  endfunction : fpp_cmd_mode

  logic init_hit;
  logic we_rise;
  logic mux_mode;
  logic blk_hit;
  logic [3:0] tgt_blk;
  logic [19:0] full_addr;

  always_comb begin
    st_next = st_reg;
    init_hit = !st_reg.init_s[1];
    we_rise = !st_reg.we_prev && st_reg.we_s[1];
    mux_mode = st_reg.sel_cap;
    full_addr = {st_reg.col, st_reg.row};
    tgt_blk = full_addr[fpp_pkg::BLK_SHIFT +: fpp_pkg::BLK_W];
    // lock pins are taken as they stand at the accepting strobe
    blk_hit = fpp_blocked(tgt_blk, st_reg.tbl_s[1], st_reg.wp_s[1], lock_bits);

    // two-flop synchronisers on every pin
    st_next.id_s = {st_reg.id_s[0], strap_identity};
    st_next.gp_s = {st_reg.gp_s[0], gp_inputs};
    st_next.tbl_s = {st_reg.tbl_s[0], top_block_lock_n};
    st_next.wp_s = {st_reg.wp_s[0], write_protect_n};
    st_next.rc_s = {st_reg.rc_s[0], row_col_select_n};
    st_next.we_s = {st_reg.we_s[0], write_strobe_n};
    st_next.oe_s = {st_reg.oe_s[0], output_gate_n};
    st_next.init_s = {st_reg.init_s[0], cpu_init_n};
    st_next.dq_s = {st_reg.dq_s[0], data_in};
    st_next.sel_s = {st_reg.sel_s[0], interface_select};
    // third stage: the edge test must never look at a first flop
    st_next.we_prev = st_reg.we_s[1];

    // mode strap read once the synchroniser holds a sample from after reset
    if (!st_reg.cap_done) begin
      if (st_reg.cap_cnt == 2'h2) begin
        st_next.sel_cap = st_reg.sel_s[1];
        st_next.cap_done = 1'b1;
      end else begin
        st_next.cap_cnt = st_reg.cap_cnt + 2'h1;
      end
    end

    st_next.cid = st_reg.id_s[1];
    st_next.boot = st_reg.id_s[1] == fpp_pkg::BOOT_ID;
    st_next.gp = st_reg.gp_s[1];
    st_next.prog = 1'b0;
    st_next.erase = 1'b0;

    // in mux mode the hub-side pins carry the address halves
    if (mux_mode) begin
      if (st_reg.rc_s[1]) begin
        st_next.row = fpp_row_bits(st_reg.id_s[1], st_reg.tbl_s[1], st_reg.wp_s[1],
                                   st_reg.gp_s[1]);
      end else begin
        st_next.col = fpp_col_bits(st_reg.id_s[1][2:0], st_reg.tbl_s[1], st_reg.wp_s[1],
                                   st_reg.gp_s[1][3:0]);
      end
    end

    // strobe edges only count in mux mode; hub cycles never reach the array
    if (we_rise && mux_mode) begin
      st_next.addr = full_addr;
      st_next.wdata = st_reg.dq_s[1];
      case (st_reg.mode)
        fpp_pkg::FPP_PROG_WAIT: begin
          if (blk_hit) begin
            st_next.refused = 1'b1;
          end else begin
            st_next.prog = 1'b1;
          end
          st_next.status = fpp_accept_status(blk_hit);
          st_next.mode = fpp_pkg::FPP_READ_STATUS;
        end
        fpp_pkg::FPP_ERASE_WAIT: begin
          // anything but the confirm byte abandons the erase
          if (st_reg.dq_s[1] == fpp_pkg::CMD_ERASE_CONFIRM) begin
            if (blk_hit) begin
              st_next.refused = 1'b1;
            end else begin
              st_next.erase = 1'b1;
            end
            st_next.status = fpp_accept_status(blk_hit);
          end
          st_next.mode = fpp_pkg::FPP_READ_STATUS;
        end
        default: begin
          st_next.mode = fpp_cmd_mode(st_reg.dq_s[1], st_reg.mode);
          if (st_reg.dq_s[1] == fpp_pkg::CMD_READ_ARRAY) begin
            // read-array is the software clear of the refusal flag
            st_next.refused = 1'b0;
          end
        end
      endcase
    end

    // read path; output gate only honoured with write strobe high
    st_next.oe = mux_mode && !st_reg.oe_s[1] && st_reg.we_s[1];
    case (st_reg.mode)
      fpp_pkg::FPP_READ_STATUS: begin
        st_next.dout = st_reg.status;
      end
      fpp_pkg::FPP_READ_ID: begin
        if (full_addr[0]) begin
          st_next.dout = fpp_pkg::DEV_CODE;
        end else begin
          st_next.dout = fpp_pkg::MFR_CODE;
        end
      end
      default: begin
        st_next.dout = array_rdata;
      end
    endcase

    // ready pin mirrors the ready bit of the status byte
    st_next.rdy = st_reg.status[7];

    // cpu init acts as a synchronous reset of mode, status, output enable and flags; address registers keep their values
    // mode capture is not repeated: the interface strap is fixed in operation
    if (init_hit) begin
      st_next.mode = fpp_pkg::FPP_READ_ARRAY;
      st_next.oe = 1'b0;
      st_next.prog = 1'b0;
      st_next.erase = 1'b0;
      st_next.refused = 1'b0;
      st_next.status = fpp_pkg::STATUS_READY;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.init_s <= 2'h3;
      st_reg.we_s <= 2'h3;
      // idle-high strobe history, so no false edge follows reset
      st_reg.we_prev <= 1'b1;
      st_reg.oe_s <= 2'h3;
      st_reg.tbl_s <= 2'h3;
      st_reg.wp_s <= 2'h3;
      st_reg.status <= fpp_pkg::STATUS_READY;
      st_reg.mode <= fpp_pkg::FPP_READ_ARRAY;
    end else begin
      st_reg <= st_next;
    end
  end

  // lock_bits is only read, never written here
  assign data_out = st_reg.dout;
  assign data_oe = st_reg.oe;
  assign component_id = st_reg.cid;
  assign is_boot_part = st_reg.boot;
  assign gp_status = st_reg.gp;
  assign hub_mode = !st_reg.sel_cap;
  assign array_addr = st_reg.addr;
  assign array_wdata = st_reg.wdata;
  assign array_program = st_reg.prog;
  assign array_erase = st_reg.erase;
  assign prot_refused = st_reg.refused;
  assign ready = st_reg.rdy;
endmodule : fpp_front
`default_nettype wire

// >>> fpp_front_properties.sv
// timing checks on the pin front end ports
`timescale 1ns/1ps
`default_nettype none
module fpp_front_properties (
  input wire logic clock,
  input wire logic reset,
  input wire logic cpu_init_n,
  input wire logic [4:0] gp_inputs,
  input wire logic output_gate_n,
  input wire logic [15:0] lock_bits,
  input wire logic data_oe,
  input wire logic [4:0] gp_status,
  input wire logic hub_mode,
  input wire logic [19:0] array_addr,
  input wire logic array_program,
  input wire logic array_erase,
  input wire logic prot_refused
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_GP: assert property ($stable(gp_inputs) [*5] |-> gp_status == gp_inputs)
    else $error("gp status lags");
  AST_LOCK: assert property (array_program || array_erase |-> !lock_bits[array_addr[19:16]])
    else $error("locked block altered");
  AST_PULSE: assert property (array_program |=> !array_program)
    else $error("long program pulse");
  AST_HUB: assert property (hub_mode |-> !(array_program || array_erase))
    else $error("write in hub mode");
  AST_REF: assert property ($rose(prot_refused) |-> !(array_program || array_erase))
    else $error("refused yet written");
  AST_OE: assert property (output_gate_n [*5] |-> !data_oe)
    else $error("data driven ungated");
  AST_INIT: assert property (!cpu_init_n [*5] |-> !(data_oe || prot_refused))
    else $error("init ignored");
  AST_RST: assert property (disable iff (1'b0) reset && $past(reset) |-> !(data_oe || array_program))
    else $error("active in reset");
endmodule : fpp_front_properties
bind fpp_front fpp_front_properties chk_u (.*);
`default_nettype wire

// >>> fpp_pkg.sv
// shared constants for the flash pin protect and address-mux front end
package fpp_pkg;
  localparam int ADDR_W = 20;
  localparam int ROW_W = 11;
  localparam int COL_W = 9;
  localparam int DATA_W = 8;
  localparam int BLK_W = 4;
  localparam int GPI_W = 5;
  localparam int ID_W = 4;
  localparam int BLK_SHIFT = 16;
  localparam logic [3:0] BOOT_ID = 4'h0;
  localparam logic [BLK_W-1:0] TOP_BLOCK = 4'hF;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] STATUS_READY = 8'h80;
  localparam logic [7:0] STATUS_PROT_ERR = 8'h02;
  localparam logic [7:0] MFR_CODE = 8'h5A;
  localparam logic [7:0] DEV_CODE = 8'hA5;
  typedef enum logic [2:0] {
    FPP_READ_ARRAY, FPP_READ_STATUS, FPP_READ_ID, FPP_PROG_WAIT, FPP_ERASE_WAIT
  } fpp_mode_t;
endpackage : fpp_pkg

// >>> fpp_prog_model.sv
// programmer model: one address-multiplexed write cycle
`timescale 1ns/1ps
`default_nettype none
module fpp_prog_model (
  input wire logic clock,
  output logic [10:0] a,
  output logic rc_n,
  output logic we_n,
  output logic [7:0] dq
);
  initial begin
    a = 11'h000;
    rc_n = 1'b1;
    we_n = 1'b1;
    dq = 8'h00;
  end
  // 4 clocks per phase, 6 after the strobe rises, so the input synchronisers see each level
  task automatic wr(input logic [19:0] ad, input logic [7:0] d);
    @(posedge clock);
    rc_n <= 1'b1;
    a <= ad[10:0];
    repeat (4) @(posedge clock);
    rc_n <= 1'b0;
    a <= {1'b0, ad[19:14], 1'b0, ad[13:11]};
    repeat (4) @(posedge clock);
    we_n <= 1'b0;
    dq <= d;
    repeat (4) @(posedge clock);
    we_n <= 1'b1;
    repeat (6) @(posedge clock);
    dq <= ~d;
  endtask : wr
endmodule : fpp_prog_model
`default_nettype wire

// >>> test_flash_pin_protect_and_mux_port.sv
// self-checking bench for the pin front end
`timescale 1ns/1ps
`default_nettype none
module test_flash_pin_protect_and_mux_port;
  logic clock = 1'b0, reset = 1'b1, cpu_init_n = 1'b1, interface_select = 1'b0;
  logic output_gate_n = 1'b1;
  logic [15:0] lock_bits = 16'h0000;
  logic [7:0] array_rdata = 8'h3C;
  wire logic [10:0] a;
  wire logic row_col_select_n, write_strobe_n, data_oe, is_boot_part, hub_mode;
  wire logic array_program, array_erase, prot_refused, ready;
  wire logic [7:0] data_in, data_out, array_wdata;
  wire logic [3:0] strap_identity = a[3:0], component_id;
  wire logic top_block_lock_n = a[4], write_protect_n = a[5];
  wire logic [4:0] gp_inputs = a[10:6], gp_status;
  wire logic [19:0] array_addr;
  int err_total = 0, n_tests = 0, n_act = 0, cyc = 0;
  logic [19:0] got_addr;
  logic [7:0] got_data;
  fpp_front dut_u (.*);
  fpp_prog_model prog_u (.clock(clock), .a(a), .rc_n(row_col_select_n),
    .we_n(write_strobe_n), .dq(data_in));
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (array_program === 1'b1 || array_erase === 1'b1) begin
      n_act <= n_act + 1;
      got_addr <= array_addr;
      got_data <= array_wdata;
    end
    if (cyc == 6000) complete_run(1'b1);
  end
  task automatic complete_run(input bit hang);
    if (hang) err_total++;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [19:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] exp);
    @(posedge clock);
    output_gate_n <= 1'b0;
    repeat (5) @(negedge clock);
    chk("data_oe", 20'h1, {19'h0, data_oe});
    chk("data_out", {12'h0, exp}, {12'h0, data_out});
    @(posedge clock);
    output_gate_n <= 1'b1;
    repeat (6) @(negedge clock);
    chk("data_oe off", 20'h0, {19'h0, data_oe});
  endtask : rd
  task automatic op(input logic [7:0] c, d, input logic [19:0] ad, input logic [15:0] lk,
      input logic ok);
    int n;
    n = n_act;
    @(posedge clock);
    lock_bits <= lk;
    prog_u.wr(ad, c);
    prog_u.wr(ad, d);
    @(negedge clock);
    chk("accepted", {19'h0, ok}, 20'(n_act - n));
    if (ok) chk("addr", ad, got_addr);
    if (ok && c == 8'h40) chk("wdata", {12'h0, d}, {12'h0, got_data});
    if (!ok) begin
      chk("refused", 20'h1, {19'h0, prot_refused});
      chk("ready", 20'h1, {19'h0, ready});
      rd(8'h82);
      prog_u.wr(ad, 8'hFF);
      rd(array_rdata);
    end
  endtask : op
  task automatic t_hub;
    chk("boot", 20'h1, {19'h0, is_boot_part});
    chk("hub", 20'h1, {19'h0, hub_mode});
    prog_u.wr(20'h3C830, 8'h40);
    repeat (4) @(negedge clock);
    chk("id", 20'h1, {16'h0, component_id});
    chk("not boot", 20'h0, {19'h0, is_boot_part});
    chk("gp", 20'h3, {15'h0, gp_status});
    chk("hub write", 20'h0, 20'(n_act));
  endtask : t_hub
  task automatic t_mux;
    chk("mux", 20'h0, {19'h0, hub_mode});
    rd(8'h3C);
    op(8'h40, 8'h5C, 20'h3C030, 16'h0000, 1'b1);
    op(8'h20, 8'hD0, 20'h3C030, 16'h0000, 1'b1);
  endtask : t_mux
  task automatic t_top;
    op(8'h40, 8'h11, 20'hFC030, 16'h8000, 1'b0);
    op(8'h40, 8'h11, 20'hFC030, 16'h0000, 1'b1);
    op(8'h40, 8'h11, 20'hF8020, 16'h0000, 1'b0);
  endtask : t_top
  task automatic t_wp;
    op(8'h40, 8'h11, 20'h34010, 16'h0000, 1'b0);
    op(8'h40, 8'h22, 20'hF4010, 16'h0000, 1'b1);
    op(8'h20, 8'hD0, 20'h3C030, 16'h0008, 1'b0);
  endtask : t_wp
  task automatic t_init;
    prog_u.wr(20'h3C030, 8'h40);
    prog_u.wr(20'h3C030, 8'h33);
    cpu_init_n <= 1'b0;
    repeat (6) @(posedge clock);
    cpu_init_n <= 1'b1;
    repeat (4) @(negedge clock);
    chk("init clears", 20'h0, {19'h0, prot_refused});
  endtask : t_init
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (7) @(negedge clock);
    t_hub;
    @(posedge clock);
    reset <= 1'b1;
    interface_select <= 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (7) @(negedge clock);
    t_mux;
    t_top;
    t_wp;
    t_init;
    complete_run(1'b0);
  end
endmodule : test_flash_pin_protect_and_mux_port
`default_nettype wire
